// ---- tsf_pkg.sv ----
/*
  Shared constants of the temperature sample queue: sizes, register
  offsets, field positions and reset values.
  Assumes byte-wide register access with an 8-bit register address.
*/
package tsf_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 16;
  localparam int DEPTH = 32;
  localparam int IDX_W = 5;
  localparam int CNT_W = 6;
  localparam int SEL_W = 2;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PUSH = 8'h04;
  localparam logic [7:0] ADDR_POP = 8'h05;
  localparam logic [7:0] ADDR_LOST = 8'h06;
  localparam logic [7:0] ADDR_COUNT = 8'h07;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_WMARK = 8'h09;
  localparam logic [7:0] ADDR_QCTL = 8'h0a;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int QCTL_FLUSH = 4;
  localparam int QCTL_CLR = 3;
  localparam int QCTL_TYPE = 2;
  localparam int QCTL_OVW = 1;
  localparam int STAT_NFULL = 7;
  localparam int STAT_CDONE = 0;
  // ------------------------------------------------------------
  // Reset values, limits and the interrupt select code
  // ------------------------------------------------------------
  localparam logic [4:0] WMARK_RST = 5'h00;
  localparam logic QCTL_BIT_RST = 1'b0;
  localparam logic [4:0] LOST_MAX = 5'h1f;
  localparam logic [1:0] INT_SEL = 2'h3;
  localparam logic [7:0] PTR_RST = 8'h00;
endpackage : tsf_pkg

// ---- tsf_sample_ram.sv ----
/*
  Sample storage of the queue: one write port, one read port whose
  data come out of a register.
  Assumes a single clock; contents are undefined after power-up.
*/
`timescale 1ns/100ps
module tsf_sample_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Array has no reset so it maps onto plain storage
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : tsf_sample_ram

// ---- tsf_link_port.sv ----
/*
  Link-clock end of the register access path: address pointer,
  request toggle towards the core and the returned byte.
  Assumes the serial protocol engine issues one access at a time.
*/
`timescale 1ns/100ps
module tsf_link_port (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic ptr_load,
  input wire logic [tsf_pkg::DATA_W-1:0] ptr_value,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [tsf_pkg::DATA_W-1:0] acc_wdata,
  output logic acc_busy,
  output logic acc_done,
  output logic [tsf_pkg::DATA_W-1:0] acc_rdata,
  output logic req_tgl,
  output logic [tsf_pkg::DATA_W-1:0] req_addr,
  output logic req_write,
  output logic [tsf_pkg::DATA_W-1:0] req_wdata,
  input wire logic ack_tgl,
  input wire logic [tsf_pkg::DATA_W-1:0] core_rdata
);
  import tsf_pkg::*;

  logic ack_s1_r;
  logic ack_s2_r;
  logic start;
  logic finish;

  assign start = !acc_busy && acc_req && !ptr_load;
  assign finish = acc_busy && (ack_s2_r == req_tgl);

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl;
      ack_s2_r <= ack_s1_r;
    end
  end

  // Request fields stay put until the core answers
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      req_tgl <= 1'b0;
      req_write <= 1'b0;
      req_wdata <= '0;
      acc_busy <= 1'b0;
    end else if (start) begin
      req_tgl <= ~req_tgl;
      req_write <= acc_write;
      req_wdata <= acc_wdata;
      acc_busy <= 1'b1;
    end else if (finish) begin
      acc_busy <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      acc_done <= 1'b0;
      acc_rdata <= '0;
    end else begin
      acc_done <= finish;
      if (finish) begin
        acc_rdata <= core_rdata;
      end
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      req_addr <= PTR_RST;
    end else if (!acc_busy && ptr_load) begin
      req_addr <= ptr_value;
    end else if (finish && req_addr != ADDR_DATA) begin
      req_addr <= req_addr + 8'h01;
    end
  end

  ptr_hold_a: assert property (@(posedge link_clk)
    disable iff (!nrst)
    finish && req_addr == ADDR_DATA |=> req_addr == ADDR_DATA)
    else $error("pointer left the data port during a burst");
  ptr_step_a: assert property (@(posedge link_clk)
    disable iff (!nrst)
    finish && req_addr != ADDR_DATA |=> req_addr == $past(req_addr) + 8'h01)
    else $error("pointer did not step after an access");
endmodule : tsf_link_port

// ---- tsf_sample_queue.sv ----
/*
  Temperature sample queue: 32 words of 16 bits, byte readout, occupancy
  and lost-word counts, near-full flag with pin interrupt, flush.
  Assumes samples arrive on ref_clk as one-cycle strobes and register
  accesses arrive from the serial engine on link_clk.
*/
`timescale 1ns/100ps
module tsf_sample_queue (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic sample_valid,
  input wire logic [tsf_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic near_full_int_en,
  input wire logic [tsf_pkg::SEL_W-1:0] pin0_function_select,
  input wire logic link_ptr_load,
  input wire logic [tsf_pkg::DATA_W-1:0] link_ptr_value,
  input wire logic link_req,
  input wire logic link_write,
  input wire logic [tsf_pkg::DATA_W-1:0] link_wdata,
  output logic link_busy,
  output logic link_done,
  output logic [tsf_pkg::DATA_W-1:0] link_rdata,
  output logic general_pin_zero,
  output logic near_full_flag,
  output logic conv_done_flag
);
  import tsf_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [IDX_W-1:0] push_index_r, push_index_nxt, pop_index_r, pop_index_nxt;
  logic [CNT_W-1:0] count_r, count_nxt, thresh;
  logic [IDX_W-1:0] lost_word_count_r, lost_word_count_nxt, wmark_r;
  logic overwrite_when_full_r, flag_type_r, clear_flags_on_data_read_r;
  logic flush_r, nfull_r, cdone_r, gp0_r, sample_d_r, cond_d_r, second_r;
  logic req_s1_r, req_s2_r, req_s3_r, ack_tgl_r, req_tgl, req_write;
  logic [DATA_W-1:0] rdata_r, rd_byte, req_addr, req_wdata;
  logic [SAMPLE_W-1:0] mem_q;
  logic acc_go, rd_data_go, stat_rd, wr_go, pop_wr, pop_go, full;
  logic push_go, room, store, lost_evt, overrun, cond, nf_set, flag_clr;

  // ------------------------------------------------------------
  // Link side and crossing
  // ------------------------------------------------------------
  tsf_link_port u_link (
    .link_clk(link_clk),
    .nrst(nrst),
    .ptr_load(link_ptr_load),
    .ptr_value(link_ptr_value),
    .acc_req(link_req),
    .acc_write(link_write),
    .acc_wdata(link_wdata),
    .acc_busy(link_busy),
    .acc_done(link_done),
    .acc_rdata(link_rdata),
    .req_tgl(req_tgl),
    .req_addr(req_addr),
    .req_write(req_write),
    .req_wdata(req_wdata),
    .ack_tgl(ack_tgl_r),
    .core_rdata(rdata_r)
  );

  // Address and data are held by the link side until the answer
  // toggles back, so only the toggle needs synchronising.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  assign acc_go = req_s2_r ^ req_s3_r;
  assign wr_go = acc_go && req_write;
  assign stat_rd = acc_go && !req_write && req_addr == ADDR_STATUS;
  assign rd_data_go = acc_go && !req_write && req_addr == ADDR_DATA;
  assign pop_wr = wr_go && req_addr == ADDR_POP;

  // ------------------------------------------------------------
  // Queue bookkeeping
  // ------------------------------------------------------------
  assign full = count_r == CNT_W'(DEPTH);
  assign pop_go = rd_data_go && second_r && count_r != '0;
  assign push_go = sample_valid && !flush_r;
  assign room = !full || pop_go;
  assign store = push_go && (room || overwrite_when_full_r);
  assign lost_evt = push_go && !room;
  assign overrun = lost_evt && overwrite_when_full_r;

  always_comb begin
    push_index_nxt = push_index_r;
    pop_index_nxt = pop_index_r;
    count_nxt = count_r;
    lost_word_count_nxt = lost_word_count_r;
    if (flush_r) begin
      push_index_nxt = '0;
      pop_index_nxt = '0;
      count_nxt = '0;
      lost_word_count_nxt = '0;
    end else begin
      if (store) begin
        push_index_nxt = push_index_r + 1'b1;
      end
      if (pop_wr) begin
        pop_index_nxt = req_wdata[IDX_W-1:0];
        count_nxt = {1'b0, IDX_W'(push_index_nxt - pop_index_nxt)};
      end else begin
        if (pop_go || overrun) begin
          pop_index_nxt = pop_index_r + 1'b1;
        end
        if (store && !overrun && !pop_go) begin
          count_nxt = count_r + 1'b1;
        end else if (pop_go && !store) begin
          count_nxt = count_r - 1'b1;
        end
      end
      if (pop_go) begin
        lost_word_count_nxt = '0;
      end else if (lost_evt && lost_word_count_r != LOST_MAX) begin
        lost_word_count_nxt = lost_word_count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      push_index_r <= '0;
      pop_index_r <= '0;
      count_r <= '0;
      lost_word_count_r <= '0;
    end else begin
      push_index_r <= push_index_nxt;
      pop_index_r <= pop_index_nxt;
      count_r <= count_nxt;
      lost_word_count_r <= lost_word_count_nxt;
    end
  end

  // Read address follows the next pop index so the head word is ready
  tsf_sample_ram #(
    .WIDTH(SAMPLE_W),
    .DEPTH(DEPTH),
    .AW(IDX_W)
  ) u_ram (
    .clk(ref_clk),
    .nrst(nrst),
    .wr_en(store),
    .wr_addr(push_index_r),
    .wr_data(sample_data),
    .rd_addr(pop_index_nxt),
    .rd_data(mem_q)
  );

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wmark_r <= WMARK_RST;
      overwrite_when_full_r <= QCTL_BIT_RST;
      flag_type_r <= QCTL_BIT_RST;
      clear_flags_on_data_read_r <= QCTL_BIT_RST;
    end else if (wr_go && req_addr == ADDR_WMARK) begin
      wmark_r <= req_wdata[IDX_W-1:0];
    end else if (wr_go && req_addr == ADDR_QCTL) begin
      overwrite_when_full_r <= req_wdata[QCTL_OVW];
      flag_type_r <= req_wdata[QCTL_TYPE];
      clear_flags_on_data_read_r <= req_wdata[QCTL_CLR];
    end
  end

  // Flush takes one cycle, then the bit drops by itself
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flush_r <= QCTL_BIT_RST;
    end else if (flush_r) begin
      flush_r <= 1'b0;
    end else if (wr_go && req_addr == ADDR_QCTL) begin
      flush_r <= req_wdata[QCTL_FLUSH];
    end
  end

  // ------------------------------------------------------------
  // Register read and byte phase
  // ------------------------------------------------------------
  always_comb begin
    rd_byte = '0;
    case (req_addr)
      ADDR_STATUS: begin
        rd_byte[STAT_NFULL] = nfull_r;
        rd_byte[STAT_CDONE] = cdone_r;
      end
      ADDR_PUSH: rd_byte = {3'h0, push_index_r};
      ADDR_POP: rd_byte = {3'h0, pop_index_r};
      ADDR_LOST: rd_byte = {3'h0, lost_word_count_r};
      ADDR_COUNT: rd_byte = {2'h0, count_r};
      ADDR_DATA: begin
        // Most significant byte goes out first
        rd_byte = second_r ? mem_q[7:0] : mem_q[15:8];
      end
      ADDR_WMARK: rd_byte = {3'h0, wmark_r};
      ADDR_QCTL: begin
        rd_byte[QCTL_FLUSH] = flush_r;
        rd_byte[QCTL_CLR] = clear_flags_on_data_read_r;
        rd_byte[QCTL_TYPE] = flag_type_r;
        rd_byte[QCTL_OVW] = overwrite_when_full_r;
      end
      default: rd_byte = '0;
    endcase
  end

  // Any access other than a data read restarts the byte pair, so a
  // host that breaks a burst simply rereads the same word.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      second_r <= 1'b0;
    end else if (flush_r) begin
      second_r <= 1'b0;
    end else if (acc_go) begin
      second_r <= rd_data_go && !second_r;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
      ack_tgl_r <= 1'b0;
    end else if (acc_go) begin
      rdata_r <= req_write ? '0 : rd_byte;
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  // ------------------------------------------------------------
  // Near-full and conversion-done flags
  // ------------------------------------------------------------
  assign thresh = CNT_W'(DEPTH) - {1'b0, wmark_r};
  assign cond = count_r >= thresh;
  assign nf_set = flag_type_r ? (cond && !cond_d_r) :
                  (cond && sample_d_r);
  assign flag_clr = stat_rd ||
                    (rd_data_go && clear_flags_on_data_read_r);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sample_d_r <= 1'b0;
      cond_d_r <= 1'b0;
    end else begin
      sample_d_r <= push_go;
      cond_d_r <= cond;
    end
  end

  // A set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nfull_r <= 1'b0;
    end else if (nf_set) begin
      nfull_r <= 1'b1;
    end else if (flag_clr) begin
      nfull_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cdone_r <= 1'b0;
    end else if (sample_d_r) begin
      cdone_r <= 1'b1;
    end else if (flag_clr) begin
      cdone_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gp0_r <= 1'b0;
    end else begin
      gp0_r <= nfull_r && near_full_int_en &&
               pin0_function_select == INT_SEL;
    end
  end

  assign general_pin_zero = gp0_r;
  assign near_full_flag = nfull_r;
  assign conv_done_flag = cdone_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  count_up_a: assert property (store && !overrun && !pop_go && !pop_wr
    |=> count_r == $past(count_r) + 1'b1)
    else $error("count did not rise on a stored sample");
  pair_pop_a: assert property (pop_go && !overrun && !store
    |=> pop_index_r == $past(pop_index_r) + 1'b1 &&
        count_r == $past(count_r) - 1'b1)
    else $error("second byte did not pop a word");
  msb_first_a: assert property (rd_data_go && !second_r
    |=> rdata_r == $past(mem_q[15:8]))
    else $error("first data byte is not the upper byte");
  overwrite_keep_a: assert property (overrun && !pop_wr
    |=> count_r == CNT_W'(DEPTH) &&
        pop_index_r == $past(pop_index_r) + 1'b1 &&
        push_index_r == $past(push_index_r) + 1'b1)
    else $error("overwrite did not keep the queue full");
  discard_full_a: assert property (lost_evt && !pop_wr &&
    !overwrite_when_full_r |=> push_index_r == $past(push_index_r) &&
        count_r == $past(count_r))
    else $error("sample stored into a full queue");
  lost_sat_a: assert property (lost_evt && !pop_go &&
    lost_word_count_r == LOST_MAX |=> lost_word_count_r == LOST_MAX)
    else $error("lost count wrapped past its maximum");
  flush_all_a: assert property (flush_r |=> !flush_r &&
    count_r == '0 && push_index_r == '0 && pop_index_r == '0 &&
    lost_word_count_r == '0)
    else $error("flush left state behind");
  pin_irq_a: assert property (nfull_r && near_full_int_en &&
    pin0_function_select == INT_SEL |=> general_pin_zero)
    else $error("interrupt pin missed the near-full flag");
  data_keep_a: assert property (rd_data_go && !stat_rd &&
    !clear_flags_on_data_read_r && nfull_r |=> nfull_r)
    else $error("data read cleared the flag");
  edge_only_a: assert property (flag_type_r && cond && cond_d_r &&
    flag_clr |=> !nfull_r)
    else $error("flag reasserted without a new condition");

  cv_overwrite_c: cover property (overrun);
  cv_flag_c: cover property (nf_set ##1 general_pin_zero);
  cv_flush_c: cover property (full ##[1:8] flush_r);
  cv_pair_c: cover property (rd_data_go ##[1:400] pop_go);
endmodule : tsf_sample_queue

// ---- tsf_host_model.sv ----
/*
  Model of the serial engine that reaches the sample queue registers.
  Assumes the link clock runs and reset has been released.
*/
`timescale 1ns/100ps
module tsf_host_model (
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic [7:0] link_rdata,
  output logic link_ptr_load,
  output logic [7:0] link_ptr_value,
  output logic link_req,
  output logic link_write,
  output logic [7:0] link_wdata
);
  logic [7:0] cur_ptr = 8'h00;
  int n_timeouts = 0;
  initial begin
    link_ptr_load = 1'b0;
    link_ptr_value = 8'h00;
    link_req = 1'b0;
    link_write = 1'b0;
    link_wdata = 8'h00;
  end
  // ------------------------------------------------------------
  // One access; the pointer is reloaded only when it moved away
  // ------------------------------------------------------------
  task automatic acc(input logic [7:0] addr, input logic wr,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    if (addr !== cur_ptr) begin
      @(posedge link_clk);
      link_ptr_load <= 1'b1;
      link_ptr_value <= addr;
      @(posedge link_clk);
      link_ptr_load <= 1'b0;
      link_ptr_value <= ~addr;
      cur_ptr = addr;
    end
    @(posedge link_clk);
    link_req <= !link_busy;
    link_write <= wr;
    link_wdata <= wd;
    @(posedge link_clk);
    link_req <= 1'b0;
    link_write <= ~wr;
    link_wdata <= ~wd;
    n = 0;
    while (link_done !== 1'b1 && n < 10) begin
      @(posedge link_clk);
      n++;
    end
    if (link_done !== 1'b1) n_timeouts++;
    rd = link_rdata;
    // Data port keeps the pointer so two reads form one word
    if (cur_ptr != 8'h08) cur_ptr = cur_ptr + 8'h01;
  endtask : acc
endmodule : tsf_host_model

// ---- tb_top.sv ----
/*
  Self-checking bench of the sample queue: samples pushed on ref_clk,
  registers reached through the engine model on link_clk.
  Assumes the design package is compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  import tsf_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] sample_data = 16'h0000;
  logic int_en = 1'b1;
  logic [1:0] sel = 2'h3;
  logic ptr_load, req, wr, busy, done, pin0, nff, cdf;
  logic [7:0] ptr_val, wdata, rdata, v;
  int fail_count = 0;
  int n_checks = 0;
  int k = 0;
  always #12.5 ref_clk = ~ref_clk;
  always #40 link_clk = ~link_clk;
  tsf_sample_queue DUT (.ref_clk(ref_clk), .nrst(nrst),
    .link_clk(link_clk), .sample_valid(sample_valid),
    .sample_data(sample_data), .near_full_int_en(int_en),
    .pin0_function_select(sel), .link_ptr_load(ptr_load),
    .link_ptr_value(ptr_val), .link_req(req), .link_write(wr),
    .link_wdata(wdata), .link_busy(busy), .link_done(done),
    .link_rdata(rdata), .general_pin_zero(pin0),
    .near_full_flag(nff), .conv_done_flag(cdf));
  tsf_host_model host (.link_clk(link_clk), .link_busy(busy),
    .link_done(done), .link_rdata(rdata), .link_ptr_load(ptr_load),
    .link_ptr_value(ptr_val), .link_req(req), .link_write(wr),
    .link_wdata(wdata));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, exp, input string nm);
    host.acc(a, 1'b0, 8'h00, v);
    chk(nm, v, exp);
  endtask : rc
  task automatic wrr(input logic [7:0] a, d);
    host.acc(a, 1'b1, d, v);
  endtask : wrr
  task automatic word(input logic [7:0] j);
    rc(ADDR_DATA, j, "data high byte");
    rc(ADDR_DATA, j ^ 8'ha5, "data low byte");
  endtask : word
  // Back-to-back samples; word j carries {j, j ^ a5}
  task automatic push(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      sample_data <= {k[7:0], k[7:0] ^ 8'ha5};
      k++;
    end
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    sample_data <= ~sample_data;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : push
  task automatic lvl(input logic [1:0] s, input logic e, exp);
    @(posedge ref_clk);
    sel <= s;
    int_en <= e;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("interrupt pin", {7'h00, pin0}, {7'h00, exp});
  endtask : lvl
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge link_clk);
    rc(ADDR_COUNT, 8'h00, "count after reset");
    chk("busy idle", {7'h00, busy}, 8'h00);
    push(3);
    rc(ADDR_COUNT, 8'h03, "count");
    rc(ADDR_PUSH, 8'h03, "push index");
    rc(ADDR_STATUS, 8'h01, "status");
    $display("test fill done");
    word(8'h00);
    rc(ADDR_COUNT, 8'h02, "count after pop");
    rc(ADDR_PUSH, 8'h03, "push index");
    rc(ADDR_POP, 8'h01, "pop index");
    wrr(ADDR_POP, 8'h00);
    rc(ADDR_COUNT, 8'h03, "count after rewind");
    word(8'h00);
    $display("test readout done");
    push(1);
    word(8'h01);
    chk("done flag kept", {7'h00, cdf}, 8'h01);
    wrr(ADDR_QCTL, 8'h08);
    rc(ADDR_DATA, 8'h02, "data high byte");
    chk("done flag cleared", {7'h00, cdf}, 8'h00);
    $display("test flag clearing done");
    wrr(ADDR_QCTL, 8'h10);
    rc(ADDR_QCTL, 8'h00, "flush bit");
    rc(ADDR_PUSH, 8'h00, "push index");
    rc(ADDR_POP, 8'h00, "pop index");
    rc(ADDR_LOST, 8'h00, "lost count");
    rc(ADDR_COUNT, 8'h00, "count");
    rc(8'h0b, 8'h00, "unmapped");
    $display("test flush done");
    k = 0;
    wrr(ADDR_WMARK, 8'h02);
    push(29);
    chk("near full early", {7'h00, nff}, 8'h00);
    chk("pin idle", {7'h00, pin0}, 8'h00);
    push(1);
    chk("near full", {7'h00, nff}, 8'h01);
    chk("pin raised", {7'h00, pin0}, 8'h01);
    lvl(2'h2, 1'b1, 1'b0);
    lvl(2'h3, 1'b0, 1'b0);
    lvl(2'h3, 1'b1, 1'b1);
    $display("test near full done");
    rc(ADDR_STATUS, 8'h81, "status");
    push(1);
    chk("near full again", {7'h00, nff}, 8'h01);
    wrr(ADDR_QCTL, 8'h04);
    rc(ADDR_STATUS, 8'h81, "status");
    push(1);
    chk("near full held off", {7'h00, nff}, 8'h00);
    $display("test flag style done");
    push(2);
    rc(ADDR_LOST, 8'h02, "lost count");
    rc(ADDR_COUNT, 8'h20, "count full");
    rc(ADDR_PUSH, 8'h00, "push index wrap");
    word(8'h00);
    rc(ADDR_LOST, 8'h00, "lost after pop");
    rc(ADDR_COUNT, 8'h1f, "count");
    $display("test discard done");
    wrr(ADDR_QCTL, 8'h02);
    push(2);
    rc(ADDR_COUNT, 8'h20, "count stays full");
    rc(ADDR_PUSH, 8'h02, "push index");
    rc(ADDR_POP, 8'h02, "pop index");
    word(8'h02);
    $display("test overwrite done");
    wrr(ADDR_QCTL, 8'h00);
    push(33);
    rc(ADDR_LOST, 8'h1f, "lost count saturated");
    rc(ADDR_COUNT, 8'h20, "count after drops");
    chk("link timeouts", host.n_timeouts[7:0], 8'h00);
    $display("test saturation done");
    tally_and_finish();
  end
endmodule : tb_top
